// ==== hw/apm_pkg.sv ====
package apm_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int ADDR_W = 28;
  localparam int DATA_W = 32;
  localparam int PAGE_WORDS = 4;
  localparam int LOW_W = 2;

  // ****************************************
  // Timing in ps and in 5 ns cycles
  // ****************************************
  localparam int CLK_PS = 5000;
  localparam int T_AVAV_PS = 45000;
  localparam int T_WLWH_PS = 25000;
  localparam int T_DVWH_PS = 15000;
  localparam int T_WHAX_PS = 15000;
  localparam int T_AA_PS = 45000;
  localparam int T_AAP_PS = 15000;
  localparam int T_WP_PS = 7500;
  localparam int T_WPH_PS = 7500;
  localparam int T_PGSL_PS = 10000;
  localparam int T_PGSH_PS = 10000;
  localparam int T_EH_PS = 10000;
  localparam int T_WLQZ_PS = 15000;

  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CYC_ONE = 5'h01;
  localparam logic [CNT_W-1:0] CYC_AA = CNT_W'((T_AA_PS + CLK_PS - 1) / CLK_PS + 1);
  localparam logic [CNT_W-1:0] CYC_AAP = CNT_W'((T_AAP_PS + CLK_PS - 1) / CLK_PS + 1);
  localparam logic [CNT_W-1:0] CYC_WL = CNT_W'((T_WLWH_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [CNT_W-1:0] CYC_WP = CNT_W'((T_WP_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [CNT_W-1:0] CYC_WPH = CNT_W'((T_WPH_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [CNT_W-1:0] CYC_WR = CNT_W'((T_WHAX_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [CNT_W-1:0] CYC_CYC = CNT_W'((T_AVAV_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [CNT_W-1:0] CYC_PGS = CNT_W'((T_PGSL_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [CNT_W-1:0] CYC_PGU = CNT_W'((T_PGSH_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [CNT_W-1:0] CYC_EH = CNT_W'((T_EH_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [CNT_W-1:0] CYC_QZ = CNT_W'((T_WLQZ_PS + CLK_PS - 1) / CLK_PS);

  // ****************************************
  // Request and answer carriers
  // ****************************************
  typedef enum logic [1:0] {
    APM_OP_READ = 2'h0,
    APM_OP_WRITE = 2'h1,
    APM_OP_WRITE_CE = 2'h2
  } apm_op_t;

  typedef struct packed {
    apm_op_t op;
    logic page;
    logic upper;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } apm_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic was_page_hit;
  } apm_rsp_t;

  typedef struct packed {
    logic ce_lower_n;
    logic ce_upper_n;
    logic oe_n;
    logic we_n;
    logic page_select_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic dq_oe;
  } apm_pins_t;

endpackage : apm_pkg

// ==== hw/apm_host.sv ====
`timescale 1ns/1ps
`default_nettype none

module apm_host (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire apm_pkg::apm_req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output apm_pkg::apm_rsp_t rsp,
  output apm_pkg::apm_pins_t pins,
  input wire logic [apm_pkg::DATA_W-1:0] dq_in
);

  // ****************************************
  // Reset and data input synchronisers
  // ****************************************
  logic rst_s1_r, rst_s2_r;
  logic [apm_pkg::DATA_W-1:0] dq_s1_r, dq_s2_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  always_ff @(posedge clk) begin
    dq_s1_r <= dq_in;
    dq_s2_r <= dq_s1_r;
  end

  // ****************************************
  // Sequencer
  // ****************************************
  typedef enum logic [8:0] {
    APM_IDLE = 9'h001,
    APM_MODE = 9'h002,
    APM_SETUP = 9'h004,
    APM_RD = 9'h008,
    APM_WR_FLOAT = 9'h010,
    APM_WR_LOW = 9'h020,
    APM_WR_HIGH = 9'h040,
    APM_RECOV = 9'h080,
    APM_DONE = 9'h100
  } apm_state_t;

  apm_state_t state_r, state_nxt;
  apm_pkg::apm_req_t cur_r, cur_nxt;
  apm_pkg::apm_pins_t pins_r, pins_nxt;
  apm_pkg::apm_rsp_t rsp_r, rsp_nxt;
  logic [apm_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic page_mode_r, page_mode_nxt;
  logic page_open_r, page_open_nxt;
  logic [apm_pkg::ADDR_W-1:apm_pkg::LOW_W] page_tag_r, page_tag_nxt;
  logic ready_r, ready_nxt;
  logic rsp_valid_r, rsp_valid_nxt;
  logic hit;

  localparam apm_pkg::apm_pins_t PINS_IDLE = '{ce_lower_n: 1'b1, ce_upper_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
    page_select_n: 1'b1, addr: '0, dq_out: '0, dq_oe: 1'b0};

  always_comb begin
    hit = page_open_r && page_mode_r && (page_tag_r == cur_r.addr[apm_pkg::ADDR_W-1:apm_pkg::LOW_W]);
    state_nxt = state_r;
    cur_nxt = cur_r;
    pins_nxt = pins_r;
    rsp_nxt = rsp_r;
    cnt_nxt = (cnt_r != '0) ? cnt_r - apm_pkg::CYC_ONE : cnt_r;
    page_mode_nxt = page_mode_r;
    page_open_nxt = page_open_r;
    page_tag_nxt = page_tag_r;
    ready_nxt = 1'b0;
    rsp_valid_nxt = 1'b0;
    case (state_r)
      APM_IDLE: begin
        ready_nxt = 1'b1;
        if (req_valid && ready_r) begin
          ready_nxt = 1'b0;
          cur_nxt = req;
          if (req.page != page_mode_r || (req.op != apm_pkg::APM_OP_READ && page_open_r && !req.page)) begin
            // Mode change with both chip enables high
            pins_nxt.ce_lower_n = 1'b1;
            pins_nxt.ce_upper_n = 1'b1;
            pins_nxt.oe_n = 1'b1;
            pins_nxt.page_select_n = !req.page;
            page_open_nxt = 1'b0;
            cnt_nxt = req.page ? apm_pkg::CYC_PGS : apm_pkg::CYC_PGU;
            state_nxt = APM_MODE;
          end else begin
            state_nxt = APM_SETUP;
          end
        end
      end
      APM_MODE: begin
        if (cnt_r == '0) begin
          page_mode_nxt = cur_r.page;
          state_nxt = APM_SETUP;
        end
      end
      APM_SETUP: begin
        // Address goes out with or before the enabling edge
        pins_nxt.addr = cur_r.addr;
        pins_nxt.dq_out = cur_r.wdata;
        pins_nxt.we_n = 1'b1;
        if (cur_r.op == apm_pkg::APM_OP_READ) begin
          pins_nxt.we_n = 1'b1;
          pins_nxt.oe_n = 1'b0;
          pins_nxt.dq_oe = 1'b0;
          pins_nxt.ce_lower_n = cur_r.upper;
          pins_nxt.ce_upper_n = !cur_r.upper;
          cnt_nxt = hit ? apm_pkg::CYC_AAP : apm_pkg::CYC_AA;
          rsp_nxt.was_page_hit = hit;
          page_open_nxt = page_mode_r;
          page_tag_nxt = cur_r.addr[apm_pkg::ADDR_W-1:apm_pkg::LOW_W];
          state_nxt = APM_RD;
        end else begin
          pins_nxt.oe_n = 1'b1;
          if (!hit && page_open_r) begin
            // New page: close the old one with a chip enable pulse
            pins_nxt.ce_lower_n = 1'b1;
            pins_nxt.ce_upper_n = 1'b1;
            page_open_nxt = 1'b0;
            cnt_nxt = apm_pkg::CYC_EH;
            state_nxt = APM_RECOV;
          end else begin
            if (cur_r.op == apm_pkg::APM_OP_WRITE) begin
              pins_nxt.ce_lower_n = cur_r.upper;
              pins_nxt.ce_upper_n = !cur_r.upper;
            end
            rsp_nxt.was_page_hit = hit;
            cnt_nxt = pins_r.oe_n ? apm_pkg::CYC_ONE : apm_pkg::CYC_QZ;
            state_nxt = APM_WR_FLOAT;
          end
        end
      end
      APM_RD: begin
        if (cnt_r == '0) begin
          rsp_nxt.rdata = dq_s2_r;
          rsp_valid_nxt = 1'b1;
          if (!page_mode_r) begin
            pins_nxt.ce_lower_n = 1'b1;
            pins_nxt.ce_upper_n = 1'b1;
            pins_nxt.oe_n = 1'b1;
          end
          cnt_nxt = page_mode_r ? '0 : apm_pkg::CYC_EH;
          state_nxt = APM_DONE;
        end
      end
      APM_WR_FLOAT: begin
        if (cnt_r == '0) begin
          pins_nxt.we_n = 1'b0;
          if (cur_r.op == apm_pkg::APM_OP_WRITE_CE) begin
            pins_nxt.ce_lower_n = cur_r.upper;
            pins_nxt.ce_upper_n = !cur_r.upper;
          end
          pins_nxt.dq_oe = 1'b1;
          cnt_nxt = hit ? apm_pkg::CYC_WP : apm_pkg::CYC_WL;
          state_nxt = APM_WR_LOW;
        end
      end
      APM_WR_LOW: begin
        if (cnt_r == '0) begin
          if (cur_r.op == apm_pkg::APM_OP_WRITE_CE && !page_mode_r) begin
            pins_nxt.ce_lower_n = 1'b1;
            pins_nxt.ce_upper_n = 1'b1;
          end else begin
            pins_nxt.we_n = 1'b1;
          end
          page_open_nxt = page_mode_r;
          page_tag_nxt = cur_r.addr[apm_pkg::ADDR_W-1:apm_pkg::LOW_W];
          cnt_nxt = hit ? apm_pkg::CYC_WPH : apm_pkg::CYC_WR;
          state_nxt = APM_WR_HIGH;
        end
      end
      APM_WR_HIGH: begin
        if (cnt_r == '0) begin
          pins_nxt.dq_oe = 1'b0;
          pins_nxt.we_n = 1'b1;
          if (!page_mode_r) begin
            pins_nxt.ce_lower_n = 1'b1;
            pins_nxt.ce_upper_n = 1'b1;
          end
          rsp_valid_nxt = 1'b1;
          cnt_nxt = page_mode_r ? '0 : apm_pkg::CYC_EH;
          state_nxt = APM_DONE;
        end
      end
      APM_RECOV: begin
        if (cnt_r == '0) begin
          state_nxt = APM_SETUP;
        end
      end
      APM_DONE: begin
        if (cnt_r == '0) begin
          ready_nxt = 1'b1;
          state_nxt = APM_IDLE;
        end
      end
      default: begin
        state_nxt = APM_IDLE;
        pins_nxt = PINS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      state_r <= APM_IDLE;
      cur_r <= '0;
      pins_r <= PINS_IDLE;
      rsp_r <= '0;
      cnt_r <= '0;
      page_mode_r <= 1'b0;
      page_open_r <= 1'b0;
      page_tag_r <= '0;
      ready_r <= 1'b0;
      rsp_valid_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cur_r <= cur_nxt;
      pins_r <= pins_nxt;
      rsp_r <= rsp_nxt;
      cnt_r <= cnt_nxt;
      page_mode_r <= page_mode_nxt;
      page_open_r <= page_open_nxt;
      page_tag_r <= page_tag_nxt;
      ready_r <= ready_nxt;
      rsp_valid_r <= rsp_valid_nxt;
    end
  end

  assign req_ready = ready_r;
  assign rsp_valid = rsp_valid_r;
  assign rsp = rsp_r;
  assign pins = pins_r;

endmodule : apm_host

`default_nettype wire

// ==== tb/apm_host_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
// ********
// Pin protocol checks
// ********
module apm_host_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire apm_pkg::apm_req_t req,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire apm_pkg::apm_rsp_t rsp,
  input wire apm_pkg::apm_pins_t pins,
  input wire logic [apm_pkg::DATA_W-1:0] dq_in
);
  logic ce_lo;
  assign ce_lo = !pins.ce_lower_n || !pins.ce_upper_n;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_oe_in_write: assert property (!pins.we_n |-> pins.oe_n) else $error("oe low in write");
  a_we_in_read: assert property (!pins.oe_n |-> pins.we_n) else $error("we low in read");
  a_one_half: assert property (pins.ce_lower_n || pins.ce_upper_n) else $error("both halves on");
  a_host_drive: assert property (pins.dq_oe |-> pins.oe_n && $past(pins.oe_n))
    else $error("dq clash");
  a_mode_change: assert property ($changed(pins.page_select_n) |-> !ce_lo)
    else $error("mode change with ce low");
  a_mode_setup: assert property ($rose(ce_lo) |-> $past(pins.page_select_n, 2) == pins.page_select_n)
    else $error("mode setup short");
  a_addr_wr: assert property (!pins.we_n |-> $stable(pins.addr)) else $error("addr moved in write");
  a_addr_rd: assert property (ce_lo && $past(ce_lo) && pins.page_select_n |-> $stable(pins.addr))
    else $error("addr moved in access");
  a_wr_width: assert property ($fell(pins.we_n) && pins.page_select_n |-> !pins.we_n [*5])
    else $error("write pulse short");
  a_pg_wr_end: assert property ($rose(pins.we_n) && !pins.page_select_n |-> ce_lo)
    else $error("page write cut");
  a_rd_start: assert property ($fell(pins.oe_n) |-> ce_lo) else $error("read without ce");
endmodule : apm_host_chk
bind apm_host apm_host_chk u_chk (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
  .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp), .pins(pins), .dq_in(dq_in));
`default_nettype wire

// ==== tb/apm_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ********
// Memory device, two halves, four-word page buffer
// ********
module apm_mem_model #(
  parameter int RD_NS = 35,
  parameter int PG_NS = 12
) (
  input wire logic ce_lower_n,
  input wire logic ce_upper_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic page_select_n,
  input wire logic [27:0] addr,
  input wire logic [31:0] dq_host,
  output logic drv,
  output logic [31:0] dq
);
  logic [31:0] mem [512];
  logic [31:0] pbuf [4];
  logic [25:0] tag;
  logic tag_ok = 1'b0;
  logic up_r = 1'b0;
  logic [31:0] pg_q;
  logic [31:0] ar_q;
  logic [31:0] rd_q;
  logic [31:0] dq_d;
  logic [27:0] a_d;
  logic [31:0] last_q = 32'h0;
  assign drv = (!ce_lower_n || !ce_upper_n) && !oe_n && we_n;
  assign #(PG_NS) pg_q = pbuf[addr[1:0]];
  assign #(RD_NS) ar_q = mem[{!ce_upper_n, addr[7:0]}];
  assign rd_q = page_select_n ? ar_q : pg_q;
  assign dq = drv ? rd_q : ~last_q;
  assign #1 dq_d = dq_host;
  assign #1 a_d = addr;
  always @(negedge drv) last_q = rd_q;
  always @(negedge ce_lower_n or negedge ce_upper_n) up_r = !ce_upper_n;
  always @(posedge we_n or posedge ce_lower_n or posedge ce_upper_n) begin
    if (!we_n || !ce_lower_n || !ce_upper_n) begin
      mem[{up_r, a_d[7:0]}] = dq_d;
    end
  end
  always @(addr or drv or page_select_n) begin
    if (!drv) begin
      tag_ok = 1'b0;
    end else if (!page_select_n && (!tag_ok || addr[27:2] != tag)) begin
      for (int i = 0; i < 4; i++) begin
        pbuf[i] = mem[{!ce_upper_n, addr[7:2], 2'(i)}];
      end
      tag = addr[27:2];
      tag_ok = 1'b1;
    end
  end
endmodule : apm_mem_model
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ********
// Testbench
// ********
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  apm_pkg::apm_req_t req = '0;
  logic req_ready;
  logic rsp_valid;
  apm_pkg::apm_rsp_t rsp;
  apm_pkg::apm_pins_t pins;
  logic dev_oe;
  logic [31:0] dq_dev;
  logic [31:0] dq_in;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  always #2.5 clk = ~clk;
  assign dq_in = pins.dq_oe ? (dev_oe ? 'x : pins.dq_out) : dq_dev;
  apm_host uut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp(rsp), .pins(pins), .dq_in(dq_in));
  apm_mem_model dev (.ce_lower_n(pins.ce_lower_n), .ce_upper_n(pins.ce_upper_n), .oe_n(pins.oe_n),
    .we_n(pins.we_n), .page_select_n(pins.page_select_n), .addr(pins.addr), .dq_host(dq_in),
    .drv(dev_oe), .dq(dq_dev));
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize
  // Ceiling far above the roughly four hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic acc(apm_pkg::apm_op_t op, logic pg, logic up, logic [27:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{op, pg, up, a, d};
    req_valid <= 1'b1;
    do @(posedge clk); while (req_ready !== 1'b1 && ++n < 99);
    req_valid <= 1'b0;
    do @(posedge clk); while (rsp_valid !== 1'b1 && ++n < 199);
    if (n >= 199) n_fail++;
  endtask : acc
  task automatic rd(logic pg, logic up, logic [27:0] a, logic [31:0] d, logic hit);
    acc(apm_pkg::APM_OP_READ, pg, up, a, 32'h0);
    chk("rdata", d, rsp.rdata);
    chk("page hit", 32'(hit), 32'(rsp.was_page_hit));
  endtask : rd
  task automatic t_reset();
    logic [5:0] idle;
    idle = {pins.ce_lower_n, pins.ce_upper_n, pins.page_select_n, pins.oe_n, pins.we_n, pins.dq_oe};
    chk("idle pins", 32'h3e, 32'(idle));
    chk("ready in reset", 32'h0, 32'(req_ready));
    rst_n <= 1'b1;
  endtask : t_reset
  task automatic t_halves();
    acc(apm_pkg::APM_OP_WRITE, 1'b0, 1'b0, 28'h5, 32'h1111aaaa);
    acc(apm_pkg::APM_OP_WRITE_CE, 1'b0, 1'b1, 28'h5, 32'h2222bbbb);
    rd(1'b0, 1'b0, 28'h5, 32'h1111aaaa, 1'b0);
    rd(1'b0, 1'b1, 28'h5, 32'h2222bbbb, 1'b0);
  endtask : t_halves
  task automatic t_page_read();
    logic [27:0] a;
    for (int i = 0; i < 5; i++) begin
      a = 28'h20 + 28'(i);
      acc(apm_pkg::APM_OP_WRITE, 1'b0, 1'b0, a, {4'ha, a});
    end
    rd(1'b1, 1'b0, 28'h22, 32'ha0000022, 1'b0);
    rd(1'b1, 1'b0, 28'h20, 32'ha0000020, 1'b1);
    rd(1'b1, 1'b0, 28'h23, 32'ha0000023, 1'b1);
    rd(1'b1, 1'b0, 28'h21, 32'ha0000021, 1'b1);
    rd(1'b1, 1'b0, 28'h24, 32'ha0000024, 1'b0);
  endtask : t_page_read
  task automatic t_page_write();
    logic [27:0] a;
    for (int i = 0; i < 4; i++) begin
      a = 28'h40 + 28'(i);
      acc(apm_pkg::APM_OP_WRITE, 1'b1, 1'b0, a, {4'hc, a});
      chk("write hit", 32'(i != 0), 32'(rsp.was_page_hit));
    end
    acc(apm_pkg::APM_OP_WRITE_CE, 1'b1, 1'b0, 28'h44, 32'hc0000044);
    chk("new page hit", 32'h0, 32'(rsp.was_page_hit));
    for (int i = 0; i < 5; i++) begin
      a = 28'h40 + 28'(i);
      rd(1'b0, 1'b0, a, {4'hc, a}, 1'b0);
    end
  endtask : t_page_write
  initial begin
    repeat (8) @(posedge clk);
    t_reset();
    t_halves();
    t_page_read();
    t_page_write();
    summarize();
  end
endmodule : tb
`default_nettype wire
